// ---- dv/lin_host_model.sv ----
// host controller model that drives the mode select pin
`timescale 1ns/100ps
module lin_host_model (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // bench command and receive pin
  input  wire logic level_cmd_i,
  input  wire logic auto_wake_i,
  input  wire logic rx_data_i,
  input  wire logic rx_oe_i,
  // mode select pin toward the device
  output logic      mode_select_n_o
);
  logic ms_q;
  // answer a low wake indication by raising select, then keep it up
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      ms_q <= 1'h0;
    else
      ms_q <= level_cmd_i | (auto_wake_i & (ms_q | (rx_oe_i & ~rx_data_i)));
  assign mode_select_n_o = ms_q;
endmodule : lin_host_model

// ---- dv/testbench.sv ----
// self-checking bench of the mode and wake controller
`timescale 1ns/100ps
module testbench;
  import lin_mode_pkg::*;
  logic       clk_i, rst_i, tx, ms_cmd, auto_w, wake_n, ext_dom, por_lo, por_hi;
  logic       rx, rx_oe, wpd, spd, regulator_inhibit_out, inh_oe, dom, term, frdy, ms_n, bus;
  logic       prev_tx;
  mode_e      mode;
  int         err_total, checked, cycles, seed, i;

  // bus is wired-and of our driver and another node
  assign bus = ~(dom | ext_dom);

  lin_mode_wake_controller #(.DOM_TIMEOUT_CYC(50)) u_lin_mode_wake_controller (
    .clk_i(clk_i), .rst_i(rst_i), .tx_data_i(tx), .mode_select_n_i(ms_n),
    .local_wake_in_n_i(wake_n), .rx_data_o(rx), .rx_oe_o(rx_oe), .tx_weak_pd_o(wpd),
    .tx_strong_pd_o(spd), .regulator_inhibit_out_o(regulator_inhibit_out), .inhibit_oe_o(inh_oe),
    .bus_level_i(bus), .bus_dominant_o(dom), .termination_en_o(term),
    .por_low_i(por_lo), .por_high_i(por_hi), .mode_o(mode), .tx_fifo_ready_o(frdy));
  lin_host_model u_lin_host_model (
    .clk_i(clk_i), .rst_i(rst_i), .level_cmd_i(ms_cmd), .auto_wake_i(auto_w),
    .rx_data_i(rx), .rx_oe_i(rx_oe), .mode_select_n_o(ms_n));
  // drive only just after the rising edge
  task cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : cyc
  task chk(input string s, input logic e, input logic g);
    checked++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s: expected %b seen %b", s, e, g);
    end
  endtask : chk
  task chk_v(input string s, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask : chk_v
  task chk_m(input mode_e e);
    chk_v("mode", {6'h0, e}, {6'h0, mode});
  endtask : chk_m
  // pin group {rx enable, weak pd, strong pd, inhibit enable}
  task pins(input logic [3:0] e);
    chk_v("pins", {4'h0, e}, {4'h0, rx_oe, wpd, spd, inh_oe});
  endtask : pins
  // receive level expected from transmit level and other node
  function logic exp_rx(input logic t, input logic x);
    return t & ~x;
  endfunction : exp_rx
  task conclude;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // hang guard, well above the expected run length
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      err_total++;
      conclude;
    end
  end

  initial
  begin
    seed = 96;
    {tx, ms_cmd, auto_w, wake_n, ext_dom, por_lo, por_hi} = 7'h49;
    rst_i = 1'b1;
    cyc(8);
    rst_i = 1'b0;
    cyc(5);
    chk_m(MODE_POWER_ON);
    pins(4'h5);
    chk("inhibit", 1'b1, regulator_inhibit_out);
    $display("test power_on done");
    // short select pulse must restart the window
    ms_cmd = 1'b1;
    cyc(500);
    ms_cmd = 1'b0;
    cyc(20);
    ms_cmd = 1'b1;
    cyc(990);
    chk_m(MODE_POWER_ON);
    cyc(20);
    chk_m(MODE_NORMAL);
    pins(4'h9);
    chk("inhibit", 1'b1, regulator_inhibit_out);
    for (i = 0; i < 40; i++)
    begin
      tx = (i % 4 == 3) ? 1'b1 : 1'($random(seed));
      ext_dom = 1'($random(seed));
      cyc(5);
      chk("bus drive", ~tx, dom);
      chk("rx", exp_rx(tx, ext_dom), rx);
    end
    {tx, ext_dom} = 2'h2;
    cyc(5);
    // stuck low transmit is cut off until a rising edge
    tx = 1'b0;
    cyc(10);
    chk("bus drive", 1'b1, dom);
    cyc(55);
    chk("bus drive", 1'b0, dom);
    tx = 1'b1;
    cyc(5);
    tx = 1'b0;
    cyc(5);
    chk("bus drive", 1'b1, dom);
    tx = 1'b1;
    $display("test normal done");
    ms_cmd = 1'b0;
    cyc(500);
    ms_cmd = 1'b1;
    cyc(10);
    chk_m(MODE_NORMAL);
    ms_cmd = 1'b0;
    cyc(1010);
    chk_m(MODE_SLEEP);
    chk("rx enable", 1'b0, rx_oe);
    chk("inhibit enable", 1'b0, inh_oe);
    chk("termination", 1'b0, term);
    tx = 1'b0;
    cyc(5);
    chk("bus drive", 1'b0, dom);
    tx = 1'b1;
    $display("test sleep done");
    wake_n = 1'b0;
    cyc(3000);
    wake_n = 1'b1;
    cyc(10);
    chk_m(MODE_SLEEP);
    wake_n = 1'b0;
    cyc(6100);
    chk_m(MODE_STANDBY);
    pins(4'hf);
    chk("rx", 1'b0, rx);
    chk("inhibit", 1'b1, regulator_inhibit_out);
    chk("termination", 1'b1, term);
    wake_n = 1'b1;
    tx = 1'b0;
    cyc(5);
    chk("bus drive", 1'b0, dom);
    tx = 1'b1;
    auto_w = 1'b1;
    cyc(4);
    chk("strong pd", 1'b0, spd);
    chk("rx enable", 1'b0, rx_oe);
    chk_m(MODE_STANDBY);
    cyc(1010);
    chk_m(MODE_NORMAL);
    chk("weak pd", 1'b0, wpd);
    {ms_cmd, auto_w} = 2'h0;
    cyc(1010);
    $display("test local_wake done");
    ext_dom = 1'b1;
    cyc(10000);
    ext_dom = 1'b0;
    cyc(10);
    chk_m(MODE_SLEEP);
    ext_dom = 1'b1;
    cyc(16100);
    chk_m(MODE_SLEEP);
    ext_dom = 1'b0;
    cyc(3);
    chk_m(MODE_STANDBY);
    pins(4'hd);
    chk("rx", 1'b0, rx);
    $display("test remote_wake done");
    {por_lo, por_hi} = 2'h2;
    cyc(5);
    chk_m(MODE_SLEEP);
    chk("strong pd", 1'b0, spd);
    por_lo = 1'b0;
    cyc(5);
    por_hi = 1'b1;
    cyc(5);
    chk_m(MODE_POWER_ON);
    chk("tx ready", 1'b1, frdy);
    $display("test supply done");
    // transmit path through the buffer: bus lags the pin by two edges
    ms_cmd = 1'b1;
    cyc(1010);
    chk_m(MODE_NORMAL);
    prev_tx = tx;
    for (i = 0; i < 12; i++)
    begin
      tx = 1'($random(seed));
      cyc(1);
      chk("bus drive", ~prev_tx, dom);
      chk("tx ready", 1'b1, frdy);
      prev_tx = tx;
    end
    tx = 1'b1;
    $display("test fifo done");
    conclude;
  end
endmodule : testbench

// ---- hdl/lin_mode_defines.svh ----
// timing and sizing constants of the mode and wake controller
`ifndef LIN_MODE_DEFINES_SVH
`define LIN_MODE_DEFINES_SVH
`define CLK_MHZ            200
`define NORMAL_ENTRY_NS    5000
`define SLEEP_ENTRY_NS     5000
`define BUS_WAKE_NS        80000
`define PIN_WAKE_NS        30000
`define DOM_TIMEOUT_US     55000
`define NS_TO_CYC(t)       (((t) * `CLK_MHZ + 999) / 1000)
`define NORMAL_ENTRY_CYC   `NS_TO_CYC(`NORMAL_ENTRY_NS)
`define SLEEP_ENTRY_CYC    `NS_TO_CYC(`SLEEP_ENTRY_NS)
`define BUS_WAKE_CYC       `NS_TO_CYC(`BUS_WAKE_NS)
`define PIN_WAKE_CYC       `NS_TO_CYC(`PIN_WAKE_NS)
`define DOM_TIMEOUT_CYC    (`DOM_TIMEOUT_US * `CLK_MHZ)
`define FIFO_DEPTH_DEF     8
`endif

// ---- hdl/lin_mode_pkg.sv ----
// types of the mode and wake controller
package lin_mode_pkg;
  typedef enum logic [1:0] {
    MODE_POWER_ON = 2'h0,
    MODE_NORMAL   = 2'h1,
    MODE_SLEEP    = 2'h3,
    MODE_STANDBY  = 2'h2
  } mode_e;

  typedef enum logic [1:0] {
    WAKE_NONE   = 2'h0,
    WAKE_REMOTE = 2'h1,
    WAKE_LOCAL  = 2'h2
  } wake_src_e;

  // pin drive group toward host and bus
  typedef struct packed {
    logic rx_o;
    logic rx_oe;
    logic tx_weak_pd;
    logic tx_strong_pd;
    logic bus_dom;
    logic inh_o;
    logic inh_oe;
    logic term_en;
  } pins_s;
endpackage : lin_mode_pkg

// ---- hdl/lin_mode_wake_controller.sv ----
// operating mode and wake-up controller of a single wire bus transceiver
`timescale 1ns/100ps
`include "lin_mode_defines.svh"

module lin_mode_wake_controller
  import lin_mode_pkg::*;
#(
  parameter int unsigned DOM_TIMEOUT_CYC = `DOM_TIMEOUT_CYC,
  parameter int unsigned FIFO_DEPTH      = `FIFO_DEPTH_DEF
)(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // host side pins
  input  wire logic tx_data_i,
  input  wire logic mode_select_n_i,
  input  wire logic local_wake_in_n_i,
  output logic      rx_data_o,
  output logic      rx_oe_o,
  output logic      tx_weak_pd_o,
  output logic      tx_strong_pd_o,
  output logic      regulator_inhibit_out_o,
  output logic      inhibit_oe_o,
  // bus side
  input  wire logic bus_level_i,
  output logic      bus_dominant_o,
  output logic      termination_en_o,
  // supply comparators
  input  wire logic por_low_i,
  input  wire logic por_high_i,
  // status
  output mode_e     mode_o,
  output logic      tx_fifo_ready_o
);
  localparam int unsigned NORM_CYC  = `NORMAL_ENTRY_CYC;
  localparam int unsigned SLEEP_CYC = `SLEEP_ENTRY_CYC;
  localparam int unsigned BUSW_CYC  = `BUS_WAKE_CYC;
  localparam int unsigned PINW_CYC  = `PIN_WAKE_CYC;
  localparam int unsigned CW        = 24;
  localparam int unsigned DW        = 32;

  initial
  begin
    if (DOM_TIMEOUT_CYC < 2 || FIFO_DEPTH < 2 || BUSW_CYC >= (1 << CW))
      $error("lin_mode_wake_controller: unsupported parameter values");
  end

  typedef struct packed {
    mode_e           mode;
    wake_src_e       src;
    logic            powered;
    logic            remote_armed;
    logic            wake_flag_clr;
    logic            dom_lock;
    logic            bus_prev;
    logic            tx_prev;
    logic            msel_prev;
    logic [CW-1:0]   norm_cnt;
    logic [CW-1:0]   sleep_cnt;
    logic [CW-1:0]   busw_cnt;
    logic [CW-1:0]   pinw_cnt;
    logic [DW-1:0]   dom_cnt;
    pins_s           pins;
  } state_s;

  state_s q, d;

  // saturating window counter, restarts when qualifying level is lost
  function automatic logic [CW-1:0] win_step(input logic qual, input logic [CW-1:0] c);
    if (!qual)
      win_step = '0;
    else if (c == {CW{1'b1}})
      win_step = c;
    else
      win_step = c + 1'b1;
  endfunction : win_step

  // transmit data passes a small fifo so the driver sees a paced stream
  logic tx_bit;
  logic tx_bit_valid;
  lin_tx_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wdata_i (tx_data_i),
    .wvalid_i(1'b1),
    .wready_o(tx_fifo_ready_o),
    .rdata_o (tx_bit),
    .rvalid_o(tx_bit_valid),
    .rready_i(1'b1)
  );
  logic tx_in;
  assign tx_in = tx_bit_valid ? tx_bit : 1'b1;

  logic norm_hit;
  logic sleep_hit;
  logic busw_hit;
  logic pinw_hit;
  assign norm_hit  = (q.norm_cnt  >= CW'(NORM_CYC));
  assign sleep_hit = (q.sleep_cnt >= CW'(SLEEP_CYC));
  assign busw_hit  = (q.busw_cnt  >  CW'(BUSW_CYC));
  assign pinw_hit  = (q.pinw_cnt  >= CW'(PINW_CYC));

  // next state and pin drive
  always_comb
  begin
    d = q;
    d.bus_prev  = bus_level_i;
    d.tx_prev   = tx_in;
    d.msel_prev = mode_select_n_i;
    d.norm_cnt  = win_step(mode_select_n_i, q.norm_cnt);
    d.sleep_cnt = win_step(!mode_select_n_i, q.sleep_cnt);
    d.pinw_cnt  = win_step(!local_wake_in_n_i && q.mode == MODE_SLEEP, q.pinw_cnt);
    d.busw_cnt  = win_step(!bus_level_i && q.mode == MODE_SLEEP &&
                           (q.busw_cnt != '0 || q.bus_prev), q.busw_cnt);
    // dominant timeout on the transmit path
    if (tx_in)
      d.dom_cnt = '0;
    else if (q.dom_cnt < DW'(DOM_TIMEOUT_CYC))
      d.dom_cnt = q.dom_cnt + 1'b1;
    // lock only while still low, else the releasing edge is masked
    if (q.dom_cnt >= DW'(DOM_TIMEOUT_CYC) && !tx_in)
      d.dom_lock = 1'b1;
    else if (tx_in && !q.tx_prev)
      d.dom_lock = 1'b0;
    if (busw_hit)
      d.remote_armed = 1'b1;
    if (mode_select_n_i && !q.msel_prev && q.mode == MODE_STANDBY)
      d.wake_flag_clr = 1'b1;
    // mode machine
    if (!q.powered)
    begin
      if (por_high_i)
      begin
        d.powered = 1'b1;
        d.mode    = MODE_POWER_ON;
      end
    end
    else if (por_low_i)
    begin
      d.mode    = MODE_SLEEP;
      d.powered = 1'b0;
    end
    else if (norm_hit)
      d.mode = MODE_NORMAL;
    else
    begin
      unique case (q.mode)
        MODE_POWER_ON: d.mode = q.mode;
        MODE_NORMAL:
          if (sleep_hit)
            d.mode = MODE_SLEEP;
        MODE_SLEEP:
          if (!mode_select_n_i && pinw_hit)
          begin
            d.mode = MODE_STANDBY;
            d.src  = WAKE_LOCAL;
          end
          else if (!mode_select_n_i && q.remote_armed && bus_level_i && !q.bus_prev)
          begin
            d.mode = MODE_STANDBY;
            d.src  = WAKE_REMOTE;
          end
        MODE_STANDBY: d.mode = q.mode;
      endcase
    end
    if (d.mode != MODE_SLEEP)
    begin
      d.remote_armed = 1'b0;
      d.busw_cnt     = '0;
    end
    if (d.mode != MODE_STANDBY)
    begin
      d.src           = WAKE_NONE;
      d.wake_flag_clr = 1'b0;
    end
    // pin drive from next mode so outputs change with the mode
    d.pins = '0;
    unique case (d.mode)
      MODE_NORMAL:
      begin
        d.pins.bus_dom = !tx_in && !d.dom_lock;
        d.pins.rx_o    = bus_level_i;
        d.pins.rx_oe   = 1'b1;
        d.pins.inh_o   = 1'b1;
        d.pins.inh_oe  = 1'b1;
        d.pins.term_en = 1'b1;
      end
      MODE_SLEEP:
      begin
        d.pins.tx_weak_pd = 1'b1;
      end
      MODE_STANDBY:
      begin
        d.pins.tx_weak_pd   = 1'b1;
        d.pins.tx_strong_pd = (d.src == WAKE_LOCAL) && !d.wake_flag_clr;
        d.pins.rx_o         = 1'b0;
        d.pins.rx_oe        = !d.wake_flag_clr;
        d.pins.inh_o        = 1'b1;
        d.pins.inh_oe       = 1'b1;
        d.pins.term_en      = 1'b1;
      end
      MODE_POWER_ON:
      begin
        d.pins.tx_weak_pd = 1'b1;
        d.pins.inh_o      = 1'b1;
        d.pins.inh_oe     = 1'b1;
        d.pins.term_en    = 1'b1;
      end
    endcase
    if (!d.powered)
      d.pins = '0;
  end

  // single state register
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      q           <= '0;
      q.mode      <= MODE_SLEEP;
      q.bus_prev  <= 1'b1;
      q.tx_prev   <= 1'b1;
      q.msel_prev <= 1'b0;
    end
    else
      q <= d;
  end

  assign rx_data_o               = q.pins.rx_o;
  assign rx_oe_o                 = q.pins.rx_oe;
  assign tx_weak_pd_o            = q.pins.tx_weak_pd;
  assign tx_strong_pd_o          = q.pins.tx_strong_pd;
  assign regulator_inhibit_out_o = q.pins.inh_o;
  assign inhibit_oe_o            = q.pins.inh_oe;
  assign bus_dominant_o          = q.pins.bus_dom;
  assign termination_en_o        = q.pins.term_en;
  assign mode_o                  = q.mode;

  a_normal_inh_high: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_o == MODE_NORMAL |-> regulator_inhibit_out_o && inhibit_oe_o)
    else $error("inhibit not high in normal mode");
  a_standby_rx_low: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_o == MODE_STANDBY && !q.wake_flag_clr |-> rx_oe_o && !rx_data_o)
    else $error("standby wake indication missing");
  a_sleep_float: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_o == MODE_SLEEP |-> !inhibit_oe_o && !termination_en_o && !rx_oe_o)
    else $error("sleep outputs not floating");
  a_no_drive_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_o != MODE_NORMAL |-> !bus_dominant_o)
    else $error("bus driven outside normal mode");
  a_sleep_entry: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(q.mode == MODE_SLEEP) && !$past(por_low_i) |-> q.sleep_cnt >= CW'(SLEEP_CYC))
    else $error("sleep entered before window");
  a_normal_entry: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(q.mode == MODE_NORMAL) |-> $past(q.norm_cnt) >= CW'(NORM_CYC))
    else $error("normal entered before window");
  a_flags_cleared: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_o != MODE_STANDBY |-> q.src == WAKE_NONE && !tx_strong_pd_o)
    else $error("wake flag outside standby");
  a_msel_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_o == MODE_STANDBY && $rose(mode_select_n_i) |=> !tx_strong_pd_o && !rx_oe_o)
    else $error("standby indications not cleared");
  a_remote_edge: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(q.mode) == MODE_SLEEP && q.mode == MODE_STANDBY && q.src == WAKE_REMOTE
    |-> $past(bus_level_i) && !$past(q.bus_prev))
    else $error("remote wake without bus rising edge");
  a_por_sleep: assert property (@(posedge clk_i) disable iff (rst_i)
    por_low_i && q.powered |=> mode_o == MODE_SLEEP)
    else $error("low supply did not force sleep");
endmodule : lin_mode_wake_controller

// parameterised fifo with valid and ready on both sides
module lin_tx_fifo #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned DEPTH = 8
)(
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // write side
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic             wvalid_i,
  output logic                  wready_o,
  // read side
  output logic [WIDTH-1:0]      rdata_o,
  output logic                  rvalid_o,
  input  wire logic             rready_i
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
    logic                        rdy;
  } fifo_s;
  fifo_s q, d;
  logic do_w;
  logic do_r;
  assign do_w = wvalid_i && (q.cnt != (AW+1)'(DEPTH));
  assign do_r = rready_i && (q.cnt != '0);

  // pointer and count update
  always_comb
  begin
    d = q;
    if (do_w)
    begin
      d.mem[q.wp] = wdata_i;
      d.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
    end
    if (do_r)
      d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
    d.cnt = q.cnt + (AW+1)'(do_w) - (AW+1)'(do_r);
    // ready kept in a flop so the port needs no decode
    d.rdy = (d.cnt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      q     <= '0;
      q.rdy <= 1'b1;
    end
    else
      q <= d;
  end

  assign wready_o = q.rdy;
  assign rvalid_o = (q.cnt != '0);
  assign rdata_o  = q.mem[q.rp];
endmodule : lin_tx_fifo
